/* design/port0_pkg.sv */
// shared constants, types and decode functions for the port0 pin block
package port0_pkg;

  localparam int NUM_PINS = 8;
  localparam int LED_PINS = 4;
  localparam int MATRIX_PINS = 9;

  localparam logic [7:0] OFF_DATA_LATCH = 8'h80;
  localparam logic [7:0] OFF_PIN_LEVEL = 8'h81;
  localparam logic [7:0] OFF_OUTPUT_ENABLE = 8'h91;
  localparam logic [7:0] OFF_LCD_BIAS = 8'h92;
  localparam logic [7:0] OFF_ANALOG_SEL = 8'haf;
  localparam logic [7:0] OFF_LED_SCAN = 8'hb1;
  localparam logic [7:0] OFF_LED_MATRIX = 8'hb3;

  localparam logic [7:0] RST_DATA_LATCH = 8'h00;
  localparam logic [7:0] RST_OUTPUT_ENABLE = 8'h00;
  localparam logic [7:0] RST_LCD_BIAS = 8'h00;
  localparam logic [7:0] RST_ANALOG_SEL = 8'h00;
  localparam logic [7:0] RST_LED_SCAN = 8'h04;
  localparam logic [7:0] RST_LED_MATRIX = 8'h00;

  localparam logic [7:0] ANALOG_SEL_MASK = 8'he0;
  localparam int ANALOG_SEL_LSB = 5;
  localparam int ANALOG_SEL_W = 3;
  localparam int LED_DUTY_LSB = 6;
  localparam int MATRIX_EN_BIT = 7;
  localparam int MATRIX_IND_W = 7;

  typedef enum logic [1:0] {
    DUTY_OFF = 2'h0,
    DUTY_1_8 = 2'h1,
    DUTY_1_9 = 2'h2,
    DUTY_1_10 = 2'h3
  } led_duty_e;

  typedef enum logic [5:0] {
    MODE_HIZ = 6'h01,
    MODE_PULLUP = 6'h02,
    MODE_PUSH = 6'h04,
    MODE_LCD = 6'h08,
    MODE_ADC = 6'h10,
    MODE_LED = 6'h20
  } pin_mode_e;

  // lcd and adc outrank the scan engine, which outranks the gpio bits
  function automatic pin_mode_e pin_mode(input logic lcd, input logic adc,
                                         input logic led, input logic oe,
                                         input logic data);
    pin_mode_e m;
    m = MODE_HIZ;
    if (lcd) m = MODE_LCD;
    else if (adc) m = MODE_ADC;
    else if (led) m = MODE_LED;
    else if (oe) m = MODE_PUSH;
    else if (data) m = MODE_PULLUP;
    return m;
  endfunction

  // segment count of the bidirectional scan, zero when off
  function automatic logic [2:0] duty_segments(input led_duty_e d);
    logic [2:0] s;
    s = 3'h0;
    unique case (d)
      DUTY_OFF: s = 3'h0;
      DUTY_1_8: s = 3'h4;
      DUTY_1_9: s = 3'h5;
      DUTY_1_10: s = 3'h6;
    endcase
    return s;
  endfunction

endpackage

/* design/pin_cfg_if.sv */
// per-pin configuration carried from the register file to the decoder
`timescale 1ns/1ps
interface pin_cfg_if;
  logic [7:0] oe;
  logic [7:0] data;
  logic [7:0] lcd;
  logic [7:0] adc;
  logic [7:0] led;
  logic [7:0] led_out;
  logic [7:0] led_oe;
  modport src (output oe, data, lcd, adc, led, led_out, led_oe);
  modport dst (input oe, data, lcd, adc, led, led_out, led_oe);
endinterface

/* design/port0_sync.sv */
// two-flop synchronizer for asynchronous pin levels
`timescale 1ns/1ps
module port0_sync #(
  parameter int WIDTH = 8
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stable_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      meta_q <= '0;
      stable_q <= '0;
    end else begin
      meta_q <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;
endmodule // port0_sync

/* design/port0_pin_decode.sv */
// combinational per-pin mode decode into pad controls
`timescale 1ns/1ps
module port0_pin_decode (
  pin_cfg_if.dst cfg,
  output logic [7:0] drive_out,
  output logic [7:0] drive_oe,
  output logic [7:0] pull_en,
  output logic [7:0] din_en,
  output logic [7:0] lcd_bias,
  output logic [7:0] analog
);
  port0_pkg::pin_mode_e mode;

  always_comb begin
    drive_out = '0;
    drive_oe = '0;
    pull_en = '0;
    din_en = '0;
    lcd_bias = '0;
    analog = '0;
    mode = port0_pkg::MODE_HIZ;
    for (int i = 0; i < port0_pkg::NUM_PINS; i++) begin
      mode = port0_pkg::pin_mode(cfg.lcd[i], cfg.adc[i], cfg.led[i],
                                 cfg.oe[i], cfg.data[i]);
      unique case (mode)
        port0_pkg::MODE_HIZ: din_en[i] = 1'b1;
        port0_pkg::MODE_PULLUP: begin
          pull_en[i] = 1'b1;
          din_en[i] = 1'b1;
        end
        port0_pkg::MODE_PUSH: begin
          drive_oe[i] = 1'b1;
          drive_out[i] = cfg.data[i];
        end
        port0_pkg::MODE_LCD: lcd_bias[i] = 1'b1;
        port0_pkg::MODE_ADC: analog[i] = 1'b1;
        port0_pkg::MODE_LED: begin
          drive_oe[i] = cfg.led_oe[i];
          drive_out[i] = cfg.led_out[i];
        end
        default: din_en[i] = 1'b1;
      endcase
    end
  end
endmodule // port0_pin_decode

/* design/port0_pin_control_mux.sv */
// port0 pin control: registers, alternate-function steering, pad outputs
`timescale 1ns/1ps
// Notes on behaviour
// - oe 0, data 0: hi-z, input on
// - oe 0, data 1: pull-up on, input on
// - oe 1: push-pull drive data, input off
// - lcd bias bit forces half-bias output
// - analog select bits 7:5 route pins 7:5
// - lcd and analog outrank output enable
// - duty field 00 off, 1/8, 1/9, 1/10
// - matrix enable turns on matrix pins 0,1
// - bits 6:0 enable matrix pins 2..8
// - alternate use ignores oe and data bits
module port0_pin_control_mux (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  output logic [7:0] pin_pullup_en,
  output logic [7:0] pin_din_en,
  output logic [7:0] pin_lcd_bias_en,
  output logic [7:0] pin_adc_en,
  input wire logic [3:0] led_drv_out,
  input wire logic [3:0] led_drv_oe,
  output logic [1:0] led_bidir_duty_select,
  output logic [2:0] led_bidir_segments,
  output logic led_matrix_enable,
  output logic [8:0] led_matrix_pins_en,
  output logic [7:0] pin_level
);

  // ---------------- register file ----------------
  logic [7:0] data_latch_q, data_latch_d;
  logic [7:0] output_enable_q, output_enable_d;
  logic [7:0] lcd_bias_q, lcd_bias_d;
  logic [7:0] analog_sel_q, analog_sel_d;
  logic [7:0] led_scan_q, led_scan_d;
  logic [7:0] led_matrix_q, led_matrix_d;

  always_comb begin
    data_latch_d = data_latch_q;
    output_enable_d = output_enable_q;
    lcd_bias_d = lcd_bias_q;
    analog_sel_d = analog_sel_q;
    led_scan_d = led_scan_q;
    led_matrix_d = led_matrix_q;
    if (reg_wr) begin
      unique case (reg_addr)
        port0_pkg::OFF_DATA_LATCH: data_latch_d = reg_wdata;
        port0_pkg::OFF_OUTPUT_ENABLE: output_enable_d = reg_wdata;
        port0_pkg::OFF_LCD_BIAS: lcd_bias_d = reg_wdata;
        // only the three select bits exist; the rest stay zero
        port0_pkg::OFF_ANALOG_SEL:
          analog_sel_d = reg_wdata & port0_pkg::ANALOG_SEL_MASK;
        port0_pkg::OFF_LED_SCAN: led_scan_d = reg_wdata;
        port0_pkg::OFF_LED_MATRIX: led_matrix_d = reg_wdata;
        default: data_latch_d = data_latch_q;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      data_latch_q <= port0_pkg::RST_DATA_LATCH;
      output_enable_q <= port0_pkg::RST_OUTPUT_ENABLE;
      lcd_bias_q <= port0_pkg::RST_LCD_BIAS;
      analog_sel_q <= port0_pkg::RST_ANALOG_SEL;
      led_scan_q <= port0_pkg::RST_LED_SCAN;
      led_matrix_q <= port0_pkg::RST_LED_MATRIX;
    end else begin
      data_latch_q <= data_latch_d;
      output_enable_q <= output_enable_d;
      lcd_bias_q <= lcd_bias_d;
      analog_sel_q <= analog_sel_d;
      led_scan_q <= led_scan_d;
      led_matrix_q <= led_matrix_d;
    end
  end

  // ---------------- led mode decode ----------------
  port0_pkg::led_duty_e duty;
  logic bidir_on;
  logic matrix_on;
  logic [8:0] matrix_pins;
  logic [7:0] led_claim;
  logic [7:0] analog_pins;

  always_comb begin
    duty = port0_pkg::led_duty_e'(led_scan_q[port0_pkg::LED_DUTY_LSB +: 2]);
    bidir_on = (duty != port0_pkg::DUTY_OFF);
    matrix_on = led_matrix_q[port0_pkg::MATRIX_EN_BIT];
    // individual enables only count while matrix mode is on
    matrix_pins = {led_matrix_q[port0_pkg::MATRIX_IND_W-1:0]
                   & {port0_pkg::MATRIX_IND_W{matrix_on}},
                   matrix_on, matrix_on};
    led_claim = '0;
    for (int i = 0; i < port0_pkg::LED_PINS; i++) begin
      led_claim[i] = bidir_on | matrix_pins[i];
    end
    analog_pins = '0;
    analog_pins[port0_pkg::ANALOG_SEL_LSB +: port0_pkg::ANALOG_SEL_W] =
      analog_sel_q[port0_pkg::ANALOG_SEL_LSB +: port0_pkg::ANALOG_SEL_W];
  end

  // ---------------- per-pin decode ----------------
  pin_cfg_if cfg ();

  assign cfg.oe = output_enable_q;
  assign cfg.data = data_latch_q;
  assign cfg.lcd = lcd_bias_q;
  assign cfg.adc = analog_pins;
  assign cfg.led = led_claim;
  assign cfg.led_out = {4'h0, led_drv_out};
  assign cfg.led_oe = {4'h0, led_drv_oe};

  logic [7:0] drive_out;
  logic [7:0] drive_oe;
  logic [7:0] pull_en;
  logic [7:0] din_en;
  logic [7:0] lcd_bias;
  logic [7:0] analog;

  port0_pin_decode u_decode (
    .cfg(cfg),
    .drive_out(drive_out),
    .drive_oe(drive_oe),
    .pull_en(pull_en),
    .din_en(din_en),
    .lcd_bias(lcd_bias),
    .analog(analog)
  );

  // ---------------- input synchronizer ----------------
  logic [7:0] pin_sync;

  port0_sync #(
    .WIDTH(port0_pkg::NUM_PINS)
  ) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  // ---------------- registered pad and status outputs ----------------
  logic [7:0] pin_out_q, pin_oe_q, pullup_q, din_en_q;
  logic [7:0] lcd_q, adc_q, level_q, level_d;
  logic [1:0] duty_q;
  logic [2:0] segs_q, segs_d;
  logic matrix_q;
  logic [8:0] matrix_pins_q;

  // a pin whose input path is off reads zero, not a stale level
  always_comb begin
    level_d = pin_sync & din_en_q;
    segs_d = port0_pkg::duty_segments(duty);
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pin_out_q <= '0;
      pin_oe_q <= '0;
      pullup_q <= '0;
      din_en_q <= 8'hff;
      lcd_q <= '0;
      adc_q <= '0;
      level_q <= '0;
      duty_q <= '0;
      segs_q <= '0;
      matrix_q <= 1'b0;
      matrix_pins_q <= '0;
    end else begin
      pin_out_q <= drive_out;
      pin_oe_q <= drive_oe;
      pullup_q <= pull_en;
      din_en_q <= din_en;
      lcd_q <= lcd_bias;
      adc_q <= analog;
      level_q <= level_d;
      duty_q <= duty;
      segs_q <= segs_d;
      matrix_q <= matrix_on;
      matrix_pins_q <= matrix_pins;
    end
  end

  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;
  assign pin_pullup_en = pullup_q;
  assign pin_din_en = din_en_q;
  assign pin_lcd_bias_en = lcd_q;
  assign pin_adc_en = adc_q;
  assign pin_level = level_q;
  assign led_bidir_duty_select = duty_q;
  assign led_bidir_segments = segs_q;
  assign led_matrix_enable = matrix_q;
  assign led_matrix_pins_en = matrix_pins_q;

  // ---------------- read port ----------------
  logic [7:0] rdata_q, rdata_d;

  // data is valid only in the cycle after the read strobe
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        port0_pkg::OFF_DATA_LATCH: rdata_d = data_latch_q;
        port0_pkg::OFF_PIN_LEVEL: rdata_d = level_q;
        port0_pkg::OFF_OUTPUT_ENABLE: rdata_d = output_enable_q;
        port0_pkg::OFF_LCD_BIAS: rdata_d = lcd_bias_q;
        port0_pkg::OFF_ANALOG_SEL: rdata_d = analog_sel_q;
        port0_pkg::OFF_LED_SCAN: rdata_d = led_scan_q;
        port0_pkg::OFF_LED_MATRIX: rdata_d = led_matrix_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

endmodule // port0_pin_control_mux

/* verif/port0_checker.sv */
// port-level checks for the port0 pin control block
`timescale 1ns/1ps
module port0_checker (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup_en,
  input wire logic [7:0] pin_din_en,
  input wire logic [7:0] pin_lcd_bias_en,
  input wire logic [7:0] pin_adc_en,
  input wire logic [1:0] led_bidir_duty_select,
  input wire logic [2:0] led_bidir_segments,
  input wire logic led_matrix_enable,
  input wire logic [8:0] led_matrix_pins_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_pullup_input_only: assert property (
    (pin_pullup_en & (pin_oe | ~pin_din_en)) == 8'h00)
    else $error("pull-up on a driven or input-off pin");
  a_drive_no_input: assert property (
    (pin_oe & pin_din_en) == 8'h00)
    else $error("input path on while driving");
  a_lcd_alone: assert property (
    (pin_lcd_bias_en & (pin_oe | pin_pullup_en | pin_din_en)) == 8'h00)
    else $error("lcd pin also driven or read");
  a_adc_alone: assert property (
    pin_adc_en[4:0] == 5'h00 &&
    (pin_adc_en & (pin_oe | pin_pullup_en | pin_din_en)) == 8'h00)
    else $error("adc pin misrouted");
  a_duty_segments: assert property (
    led_bidir_segments == ((led_bidir_duty_select == 2'h0) ? 3'h0 :
      {1'b0, led_bidir_duty_select} + 3'h3))
    else $error("segment count does not match duty");
  a_duty_write: assert property (
    reg_wr && reg_addr == port0_pkg::OFF_LED_SCAN |->
    ##2 led_bidir_duty_select == $past(reg_wdata[7:6], 2))
    else $error("duty field not taken from write");
  a_matrix_write: assert property (
    reg_wr && reg_addr == port0_pkg::OFF_LED_MATRIX |->
    ##2 led_matrix_enable == $past(reg_wdata[7], 2))
    else $error("matrix enable not taken from write");
  a_matrix_pair: assert property (
    led_matrix_pins_en[1:0] == {2{led_matrix_enable}})
    else $error("matrix pins 0 and 1 not tied to enable");
  a_matrix_gate: assert property (
    !led_matrix_enable |-> led_matrix_pins_en == 9'h000)
    else $error("matrix pin enabled while matrix off");
  a_rdata_idle: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  c_pullup: cover property (pin_pullup_en != 8'h00);
  c_lcd_over_oe: cover property (pin_lcd_bias_en != 8'h00 && pin_oe != 8'h00);
  c_matrix: cover property (led_matrix_enable);
endmodule // port0_checker

bind port0_pin_control_mux port0_checker port0_checker_inst (
  .mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .pin_oe, .pin_pullup_en, .pin_din_en, .pin_lcd_bias_en, .pin_adc_en,
  .led_bidir_duty_select, .led_bidir_segments, .led_matrix_enable,
  .led_matrix_pins_en
);

/* verif/port0_pads.sv */
// pad model: each pin level from the block, an outside source, pull-up or a toggling float value
`timescale 1ns/1ps
module port0_pads (
  input wire logic mclk,
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_pullup_en,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pin_in
);
  // a floating pin wanders, so no check may lean on its level
  logic [7:0] float_q = 8'h55;
  always_ff @(posedge mclk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pin_oe[i]) pin_in[i] = pin_out[i];
      else if (ext_en[i]) pin_in[i] = ext_val[i];
      else if (pin_pullup_en[i]) pin_in[i] = 1'b1;
      else pin_in[i] = float_q[i];
    end
  end
endmodule // port0_pads

/* verif/tb.sv */
// self-checking bench for the port0 pin control block
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] led_drv_out = 4'h5;
  logic [3:0] led_drv_oe = 4'h6;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] reg_rdata, pin_in, pin_out, pin_oe, pin_pullup_en, pin_din_en;
  logic [7:0] pin_lcd_bias_en, pin_adc_en, pin_level;
  logic [1:0] led_bidir_duty_select;
  logic [2:0] led_bidir_segments;
  logic led_matrix_enable;
  logic [8:0] led_matrix_pins_en;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;

  always #5 mclk = ~mclk;

  port0_pin_control_mux port0_pin_control_mux_inst (
    .mclk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pin_in, .pin_out, .pin_oe, .pin_pullup_en, .pin_din_en,
    .pin_lcd_bias_en, .pin_adc_en, .led_drv_out, .led_drv_oe,
    .led_bidir_duty_select, .led_bidir_segments, .led_matrix_enable,
    .led_matrix_pins_en, .pin_level);
  port0_pads port0_pads_inst (.mclk, .pin_out, .pin_oe, .pin_pullup_en,
    .ext_en, .ext_val, .pin_in);

  task automatic print_verdict();
    if (fails == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // pad outputs follow a write one edge late; wait two to be clear of it
  task automatic settle();
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // pin_out only means something where the pin drives
  task automatic pads(input logic [7:0] o, e, pu, di);
    chk(pin_out & pin_oe, o);
    chk(pin_oe, e);
    chk(pin_pullup_en, pu);
    chk(pin_din_en, di);
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      print_verdict();
    end
  end

  initial begin
    logic [7:0] offs [6] = '{8'h80, 8'h91, 8'h92, 8'haf, 8'hb1, 8'hb3};
    logic [7:0] rsts [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00};
    logic [2:0] segs [4] = '{3'h0, 3'h4, 3'h5, 3'h6};
    logic [1:0] dv;
    repeat (5) @(posedge mclk);
    chk(pin_din_en, 8'hff);
    resetn <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 6; i++) rd(offs[i], rsts[i]);
    wr(8'h82, 8'hff);
    rd(8'h82, 8'h00);
    settle();
    pads(8'h00, 8'h00, 8'h00, 8'hff);
    wr(8'h80, 8'hff);
    settle();
    pads(8'h00, 8'h00, 8'hff, 8'hff);
    wr(8'h91, 8'hff);
    wr(8'h80, 8'ha5);
    settle();
    pads(8'ha5, 8'hff, 8'h00, 8'h00);
    wr(8'h92, 8'h0f);
    settle();
    chk(pin_lcd_bias_en, 8'h0f);
    pads(8'ha0, 8'hf0, 8'h00, 8'h00);
    for (int i = 5; i < 8; i++) begin
      wr(8'haf, 8'h01 << i);
      settle();
      chk(pin_adc_en, 8'h01 << i);
      chk(pin_oe, 8'hf0 & ~(8'h01 << i));
    end
    wr(8'haf, 8'hff);
    rd(8'haf, 8'he0);
    wr(8'haf, 8'h00);
    wr(8'h92, 8'h00);
    wr(8'h80, 8'h0a);
    for (int d = 0; d < 4; d++) begin
      dv = 2'(d);
      wr(8'hb1, {dv, 6'h04});
      settle();
      chk(led_bidir_duty_select, dv);
      chk(led_bidir_segments, segs[d]);
      chk(pin_oe[3:0], (d == 0) ? 4'hf : 4'h6);
      chk(pin_out[3:0] & pin_oe[3:0], (d == 0) ? 4'ha : 4'h4);
      rd(8'hb1, {dv, 6'h04});
    end
    wr(8'hb1, 8'h04);
    wr(8'hb3, 8'h80);
    settle();
    chk(led_matrix_pins_en, 9'h003);
    chk(led_matrix_enable, 1'b1);
    chk(pin_out[3:0] & pin_oe[3:0], 4'h8);
    wr(8'hb3, 8'h7f);
    settle();
    chk(led_matrix_pins_en, 9'h000);
    chk(led_matrix_enable, 1'b0);
    rd(8'hb3, 8'h7f);
    wr(8'hb3, 8'hff);
    settle();
    chk(led_matrix_pins_en, 9'h1ff);
    chk(pin_oe[3:0], 4'h6);
    wr(8'hb3, 8'h00);
    wr(8'h91, 8'hf8);
    wr(8'h80, 8'hf0);
    settle();
    pads(8'hf0, 8'hf8, 8'h00, 8'h07);
    wr(8'h91, 8'h00);
    wr(8'h80, 8'h00);
    reg_wr <= 1'b0;
    ext_en <= 8'hff;
    ext_val <= 8'h5a;
    repeat (4) @(posedge mclk);
    #1;
    chk(pin_level, 8'h5a);
    rd(8'h81, 8'h5a);
    wr(8'h81, 8'hff);
    rd(8'h80, 8'h00);
    @(posedge mclk);
    ext_val <= 8'ha5;
    repeat (2) @(posedge mclk);
    #1;
    chk(pin_level, 8'h5a);
    @(posedge mclk);
    #1;
    chk(pin_level, 8'ha5);
    print_verdict();
  end
endmodule // tb
